// file: pkg/fcc_pkg.sv
package fcc_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_RES = 5'h04;
  localparam logic [4:0] OFS_NUM = 5'h08;
  localparam logic [4:0] OFS_DEN = 5'h0c;
  localparam logic [4:0] OFS_EXT = 5'h10;
  localparam logic [4:0] OFS_CMD = 5'h14;
  localparam logic [4:0] OFS_RATE = 5'h18;

  // Control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_SEL_W = 3;
  localparam int CTRL_EN_BIT = 8;

  // Command source codes
  localparam logic [2:0] SRC_CTL_QUAD = 3'h0;
  localparam logic [2:0] SRC_CTL_UPDN = 3'h2;
  localparam logic [2:0] SRC_MACH_QUAD = 3'h3;

  // Reset values
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic RST_EN = 1'b0;
  localparam logic [15:0] RST_RES = 16'h0001;
  localparam logic [15:0] RST_NUM = 16'h0001;
  localparam logic [15:0] RST_DEN = 16'h0001;

  // Motor counts per revolution, plain default
  localparam logic [15:0] MOTOR_COUNTS_PER_REV = 16'h1000;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int RATE_WINDOW_US = 1000;
  localparam int RATE_WINDOW_CYCLES = RATE_WINDOW_US * CLK_MHZ;

  typedef enum logic [0:0] {ST_IDLE, ST_DRAIN} fcc_state_t;

endpackage

// file: src/fcc_edge_decoder.sv
`timescale 1ns/1ps
module fcc_edge_decoder (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic a,
  input wire logic b,
  input wire logic updown,
  output logic inc,
  output logic dec
);

  logic prev_a_r;
  logic prev_b_r;
  wire ch_a = a ^ prev_a_r;
  wire ch_b = b ^ prev_b_r;
  wire one_ch = ch_a ^ ch_b;
  wire fwd = a ^ prev_b_r;
  wire rise_a = a & ~prev_a_r;
  wire rise_b = b & ~prev_b_r;
  // Every edge on one channel alone counts, both changing in one cycle counts nothing, A leading B counts up
  wire q_inc = one_ch & fwd;
  wire q_dec = one_ch & ~fwd;
  // Up line rises count up, down line rises count down
  wire u_inc = rise_a & ~rise_b;
  wire u_dec = rise_b & ~rise_a;

  assign inc = updown ? u_inc : q_inc;
  assign dec = updown ? u_dec : q_dec;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_a_r <= 1'b0;
      prev_b_r <= 1'b0;
    end
    else
    begin
      prev_a_r <= a;
      prev_b_r <= b;
    end
  end

endmodule

// file: src/fcc_follower.sv
`timescale 1ns/1ps
// Operation
// - Quadrature phase order sets count direction
// - Resolution equal lines, unity ratio: one revolution in quadrature, a quarter revolution in up/down
// - Source 0: quadrature on controller pair
// - Source 3: quadrature on machine pair
// - Up/down: A pulse increments count
// - Up/down: B pulse decrements count
// - Source 2: controller pair as up/down
// - Speed from pulse rate, travel from count
// - Scale by numerator, denominator, resolution
// - Negative numerator reverses command direction
// - Increments pass only while following enabled
module fcc_follower #(
  parameter int RATE_WINDOW_CYCLES = fcc_pkg::RATE_WINDOW_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ctl_a,
  input wire logic ctl_b,
  input wire logic mach_a,
  input wire logic mach_b,
  output logic [31:0] pos_cmd,
  output logic cmd_step_up,
  output logic cmd_step_down
);

  logic [2:0] command_source_select_r;
  logic follow_en_r;
  logic [15:0] external_line_resolution_r;
  logic [15:0] ratio_numerator_r;
  logic [15:0] ratio_denominator_r;
  logic [31:0] external_position_count_r;
  logic [31:0] consumed_r;
  logic signed [47:0] resid_r;
  logic [31:0] motor_cmd_r;
  logic [31:0] rate_r;
  logic [31:0] win_sum_r;
  logic [31:0] win_cnt_r;
  logic step_up_r;
  logic step_down_r;
  logic ack_r;
  logic [31:0] readdata_r;
  fcc_pkg::fcc_state_t state_r;

  // Bus slave: one wait cycle, read data captured at the first edge
  wire req = avs_read | avs_write;
  wire wr_fire = avs_write & ack_r;
  wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [4:0] word_addr = {avs_address[4:2], 2'b00};
  wire sel_ctrl = word_addr == fcc_pkg::OFS_CTRL;
  wire sel_res = word_addr == fcc_pkg::OFS_RES;
  wire sel_num = word_addr == fcc_pkg::OFS_NUM;
  wire sel_den = word_addr == fcc_pkg::OFS_DEN;
  wire sel_ext = word_addr == fcc_pkg::OFS_EXT;
  wire sel_cmd = word_addr == fcc_pkg::OFS_CMD;
  wire sel_rate = word_addr == fcc_pkg::OFS_RATE;
  wire [31:0] ctrl_word = {23'h0, follow_en_r, 5'h0, command_source_select_r};
  wire [31:0] ctrl_nxt = (ctrl_word & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] res_nxt = ({16'h0, external_line_resolution_r} & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] num_nxt = ({16'h0, ratio_numerator_r} & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] den_nxt = ({16'h0, ratio_denominator_r} & ~be_mask) | (avs_writedata & be_mask);
  wire [31:0] rd_mux = sel_ctrl ? ctrl_word :
                       sel_res ? {16'h0, external_line_resolution_r} :
                       sel_num ? {16'h0, ratio_numerator_r} :
                       sel_den ? {16'h0, ratio_denominator_r} :
                       sel_ext ? external_position_count_r :
                       sel_cmd ? motor_cmd_r :
                       sel_rate ? rate_r : 32'h0;

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = readdata_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      readdata_r <= 32'h0;
    end
    else
    begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r)
        readdata_r <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      command_source_select_r <= fcc_pkg::RST_SEL;
      follow_en_r <= fcc_pkg::RST_EN;
      external_line_resolution_r <= fcc_pkg::RST_RES;
      ratio_numerator_r <= fcc_pkg::RST_NUM;
      ratio_denominator_r <= fcc_pkg::RST_DEN;
    end
    else if (wr_fire)
    begin
      if (sel_ctrl)
      begin
        command_source_select_r <= ctrl_nxt[fcc_pkg::CTRL_SEL_LSB +: fcc_pkg::CTRL_SEL_W];
        follow_en_r <= ctrl_nxt[fcc_pkg::CTRL_EN_BIT];
      end
      if (sel_res)
        external_line_resolution_r <= res_nxt[15:0];
      if (sel_num)
        ratio_numerator_r <= num_nxt[15:0];
      if (sel_den)
        ratio_denominator_r <= den_nxt[15:0];
    end
  end

  // Input port and decoding style selection
  wire src_ctl_quad = command_source_select_r == fcc_pkg::SRC_CTL_QUAD;
  wire src_ctl_updn = command_source_select_r == fcc_pkg::SRC_CTL_UPDN;
  wire src_mach_quad = command_source_select_r == fcc_pkg::SRC_MACH_QUAD;
  wire src_valid = src_ctl_quad | src_ctl_updn | src_mach_quad;
  // Machine pair only carries quadrature, up/down stays on controller pair
  wire in_a = src_mach_quad ? mach_a : ctl_a;
  wire in_b = src_mach_quad ? mach_b : ctl_b;
  wire dec_inc;
  wire dec_dec;

  fcc_edge_decoder u_dec (
    .core_clk(core_clk),
    .rst(rst),
    .a(in_a),
    .b(in_b),
    .updown(src_ctl_updn),
    .inc(dec_inc),
    .dec(dec_dec)
  );

  wire cnt_up = src_valid & dec_inc;
  wire cnt_dn = src_valid & dec_dec;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      external_position_count_r <= 32'h0;
    else if (cnt_up)
      external_position_count_r <= external_position_count_r + 32'h1;
    else if (cnt_dn)
      external_position_count_r <= external_position_count_r - 32'h1;
  end

  // Gearing: each count adds numerator*motor_res, one motor count per divisor
  wire signed [32:0] step_val = $signed(ratio_numerator_r) * $signed({1'b0, fcc_pkg::MOTOR_COUNTS_PER_REV});
  wire [31:0] den_res = ratio_denominator_r * external_line_resolution_r;
  wire signed [47:0] divisor = $signed({14'h0, den_res, 2'b00});
  wire signed [47:0] step_ext = 48'(step_val);
  wire [31:0] pending = external_position_count_r - consumed_r;
  wire pend_pos = ~pending[31] & (pending != 32'h0);
  wire pend_neg = pending[31];
  wire gear_ok = follow_en_r & (ratio_denominator_r != 16'h0) & (external_line_resolution_r != 16'h0);
  wire over_pos = resid_r >= divisor;
  wire over_neg = resid_r <= -divisor;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= fcc_pkg::ST_IDLE;
      consumed_r <= 32'h0;
      resid_r <= 48'sh0;
      motor_cmd_r <= 32'h0;
      step_up_r <= 1'b0;
      step_down_r <= 1'b0;
    end
    else
    begin
      step_up_r <= 1'b0;
      step_down_r <= 1'b0;
      case (state_r)
        fcc_pkg::ST_IDLE:
        begin
          if (!gear_ok)
          begin
            consumed_r <= external_position_count_r;
            resid_r <= 48'sh0;
          end
          else if (pend_pos)
          begin
            consumed_r <= consumed_r + 32'h1;
            resid_r <= resid_r + step_ext;
            state_r <= fcc_pkg::ST_DRAIN;
          end
          else if (pend_neg)
          begin
            consumed_r <= consumed_r - 32'h1;
            resid_r <= resid_r - step_ext;
            state_r <= fcc_pkg::ST_DRAIN;
          end
        end
        fcc_pkg::ST_DRAIN:
        begin
          if (over_pos)
          begin
            resid_r <= resid_r - divisor;
            motor_cmd_r <= motor_cmd_r + 32'h1;
            step_up_r <= 1'b1;
          end
          else if (over_neg)
          begin
            resid_r <= resid_r + divisor;
            motor_cmd_r <= motor_cmd_r - 32'h1;
            step_down_r <= 1'b1;
          end
          else
            state_r <= fcc_pkg::ST_IDLE;
        end
        default: state_r <= fcc_pkg::ST_IDLE;
      endcase
    end
  end

  // Commanded speed: motor counts per rate window
  wire win_end = win_cnt_r == 32'(RATE_WINDOW_CYCLES - 1);
  wire [31:0] win_delta = step_up_r ? 32'h1 : (step_down_r ? 32'hffff_ffff : 32'h0);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      win_cnt_r <= 32'h0;
      win_sum_r <= 32'h0;
      rate_r <= 32'h0;
    end
    else if (win_end)
    begin
      win_cnt_r <= 32'h0;
      win_sum_r <= 32'h0;
      rate_r <= win_sum_r + win_delta;
    end
    else
    begin
      win_cnt_r <= win_cnt_r + 32'h1;
      win_sum_r <= win_sum_r + win_delta;
    end
  end

  assign pos_cmd = motor_cmd_r;
  assign cmd_step_up = step_up_r;
  assign cmd_step_down = step_down_r;

  AST_QUAD_A_LEADS: assert property (@(posedge core_clk) disable iff (rst)
    (src_ctl_quad && $stable(command_source_select_r) && $rose(ctl_a) && !ctl_b && $stable(ctl_b))
    |=> external_position_count_r == $past(external_position_count_r) + 32'h1)
    else $error("A leading B did not count up");

  AST_QUAD_B_LEADS: assert property (@(posedge core_clk) disable iff (rst)
    (src_mach_quad && $stable(command_source_select_r) && $rose(mach_b) && !mach_a && $stable(mach_a))
    |=> external_position_count_r == $past(external_position_count_r) - 32'h1)
    else $error("B leading A did not count down");

  AST_CTL_PORT_ONLY: assert property (@(posedge core_clk) disable iff (rst)
    (src_ctl_quad && $stable(command_source_select_r) && $stable(ctl_a) && $stable(ctl_b))
    |=> $stable(external_position_count_r))
    else $error("Controller quadrature counted without controller edge");

  AST_MACH_PORT_ONLY: assert property (@(posedge core_clk) disable iff (rst)
    (src_mach_quad && $stable(command_source_select_r) && $stable(mach_a) && $stable(mach_b))
    |=> $stable(external_position_count_r))
    else $error("Machine quadrature counted without machine edge");

  AST_UP_PULSE: assert property (@(posedge core_clk) disable iff (rst)
    (src_ctl_updn && $stable(command_source_select_r) && $rose(ctl_a) && !$rose(ctl_b))
    |=> external_position_count_r == $past(external_position_count_r) + 32'h1)
    else $error("Up pulse did not increment");

  AST_DOWN_PULSE: assert property (@(posedge core_clk) disable iff (rst)
    (src_ctl_updn && $stable(command_source_select_r) && $rose(ctl_b) && !$rose(ctl_a))
    |=> external_position_count_r == $past(external_position_count_r) - 32'h1)
    else $error("Down pulse did not decrement");

  AST_UPDN_FALL_IGNORED: assert property (@(posedge core_clk) disable iff (rst)
    (src_ctl_updn && $stable(command_source_select_r) && !$rose(ctl_a) && !$rose(ctl_b))
    |=> $stable(external_position_count_r))
    else $error("Up/down counted without a rising pulse");

  AST_RESID_BOUND: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == fcc_pkg::ST_DRAIN && !over_pos && !over_neg)
    |=> state_r == fcc_pkg::ST_IDLE && resid_r < divisor && resid_r > -divisor)
    else $error("Residue left outside one divisor");

  AST_NEG_RATIO_DIR: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == fcc_pkg::ST_IDLE && gear_ok && pend_pos && ratio_numerator_r[15] && !over_pos)
    |=> ##[1:2] !step_up_r)
    else $error("Negative ratio stepped motor forward");

  AST_DISABLED_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    (state_r == fcc_pkg::ST_IDLE && !follow_en_r) |=> $stable(motor_cmd_r) ##1 $stable(motor_cmd_r))
    else $error("Motor command moved while following disabled");

  AST_STEP_PULSE: assert property (@(posedge core_clk) disable iff (rst)
    step_up_r |-> motor_cmd_r == $past(motor_cmd_r) + 32'h1 && !step_down_r)
    else $error("Step pulse does not match command change");

endmodule

// file: tb/fcc_master_model.sv
`timescale 1ns/1ps
module fcc_master_model (
  input wire logic core_clk,
  output logic a,
  output logic b
);
  logic [1:0] ph;

  initial
  begin
    a = 1'b0;
    b = 1'b0;
    ph = 2'h0;
  end

  // One quadrature edge per step, each state held two cycles; fwd has A leading B
  task automatic quad(input int edges, input bit fwd);
    for (int i = 0; i < edges; i++)
    begin
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      @(posedge core_clk);
      a <= ph[0] ^ ph[1];
      b <= ph[1];
      @(posedge core_clk);
    end
  endtask

  // Pulses on A count up, pulses on B count down
  task automatic updn(input int n, input bit up);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      if (up)
        a <= 1'b1;
      else
        b <= 1'b1;
      repeat (2) @(posedge core_clk);
      a <= 1'b0;
      b <= 1'b0;
      @(posedge core_clk);
    end
  endtask
endmodule

// file: tb/fcc_follower_tb.sv
`timescale 1ns/1ps
module fcc_follower_tb;
  logic core_clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [3:0] be;
  logic [31:0] net_steps;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ctl_a;
  logic ctl_b;
  logic mach_a;
  logic mach_b;
  logic [31:0] pos_cmd;
  logic cmd_step_up;
  logic cmd_step_down;
  logic [31:0] v;
  int num_errors;
  int checked;
  int cyc;

  fcc_follower #(.RATE_WINDOW_CYCLES(16)) DUT (
    .core_clk(core_clk),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .ctl_a(ctl_a),
    .ctl_b(ctl_b),
    .mach_a(mach_a),
    .mach_b(mach_b),
    .pos_cmd(pos_cmd),
    .cmd_step_up(cmd_step_up),
    .cmd_step_down(cmd_step_down)
  );

  fcc_master_model m_ctl (.core_clk(core_clk), .a(ctl_a), .b(ctl_b));
  fcc_master_model m_mach (.core_clk(core_clk), .a(mach_a), .b(mach_b));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic print_verdict;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // Net motor steps seen on the pulse outputs
  always @(posedge core_clk)
  begin
    if (cmd_step_up === 1'b1)
      net_steps <= net_steps + 32'h1;
    else if (cmd_step_down === 1'b1)
      net_steps <= net_steps - 32'h1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request held until waitrequest is seen low
  task automatic bus(input logic [4:0] ad, input logic wr_en, input logic [31:0] wd, output logic [31:0] rd_v);
    @(posedge core_clk);
    avs_address <= ad;
    avs_write <= wr_en;
    avs_read <= !wr_en;
    avs_writedata <= wd;
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] ad, input logic [31:0] d);
    bus(ad, 1'b1, d, v);
  endtask

  task automatic rd(input logic [4:0] ad, input logic [31:0] exp);
    bus(ad, 1'b0, 32'h0, v);
    chk(v, exp);
  endtask

  task automatic ctrl(input logic [2:0] sel, input logic en);
    wr(fcc_pkg::OFS_CTRL, {23'h0, en, 5'h0, sel});
  endtask

  // Waits until the motor command has stopped stepping
  task automatic settle;
    int q;
    q = 0;
    while (q < 12)
    begin
      @(posedge core_clk);
      q = (cmd_step_up === 1'b1 || cmd_step_down === 1'b1) ? 0 : q + 1;
    end
  endtask

  initial
  begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    be = 4'hf;
    net_steps = 32'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rd(fcc_pkg::OFS_CTRL, 32'h0);
    rd(fcc_pkg::OFS_NUM, 32'h1);
    rd(fcc_pkg::OFS_DEN, 32'h1);
    rd(fcc_pkg::OFS_RES, 32'h1);
    rd(fcc_pkg::OFS_EXT, 32'h0);
    rd(fcc_pkg::OFS_CMD, 32'h0);
    wr(fcc_pkg::OFS_RES, 32'h10);
    ctrl(fcc_pkg::SRC_CTL_QUAD, 1'b1);
    rd(fcc_pkg::OFS_CTRL, 32'h100);
    m_ctl.quad(64, 1'b1);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h40);
    rd(fcc_pkg::OFS_CMD, 32'h1000);
    chk(pos_cmd, 32'h1000);
    chk(net_steps, 32'h1000);
    m_ctl.quad(64, 1'b0);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h0);
    rd(fcc_pkg::OFS_CMD, 32'h0);
    ctrl(fcc_pkg::SRC_MACH_QUAD, 1'b1);
    m_mach.quad(16, 1'b1);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h10);
    rd(fcc_pkg::OFS_CMD, 32'h400);
    m_mach.quad(4, 1'b0);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'hc);
    rd(fcc_pkg::OFS_CMD, 32'h300);
    m_mach.quad(4, 1'b1);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h10);
    ctrl(fcc_pkg::SRC_CTL_UPDN, 1'b1);
    m_ctl.updn(3, 1'b1);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h13);
    rd(fcc_pkg::OFS_CMD, 32'h4c0);
    m_ctl.updn(2, 1'b0);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h11);
    rd(fcc_pkg::OFS_CMD, 32'h440);
    wr(fcc_pkg::OFS_NUM, 32'hffff);
    m_ctl.updn(2, 1'b1);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h13);
    rd(fcc_pkg::OFS_CMD, 32'h3c0);
    ctrl(fcc_pkg::SRC_CTL_UPDN, 1'b0);
    m_ctl.updn(4, 1'b1);
    settle();
    rd(fcc_pkg::OFS_EXT, 32'h17);
    rd(fcc_pkg::OFS_CMD, 32'h3c0);
    chk(pos_cmd, 32'h3c0);
    chk(net_steps, 32'h3c0);
    wr(fcc_pkg::OFS_EXT, 32'h12345678);
    rd(fcc_pkg::OFS_EXT, 32'h17);
    rd(5'h1c, 32'h0);
    rd(fcc_pkg::OFS_RATE, 32'h0);
    be = 4'h2;
    wr(fcc_pkg::OFS_RES, 32'hffff_ab00);
    rd(fcc_pkg::OFS_RES, 32'hab10);
    print_verdict();
  end
endmodule
